// *** logic/pwl_pkg.sv ***
package pwl_pkg;
  // register addressing: domain code plus offset within the domain
  localparam int         DOM_W        = 2;
  localparam int         OFS_W        = 3;
  localparam logic [1:0] DOM_PACKAGE  = 2'h0;
  localparam logic [1:0] DOM_CORE     = 2'h1;
  localparam logic [1:0] DOM_GRAPHICS = 2'h2;
  localparam logic [1:0] DOM_UNIT     = 2'h3;
  localparam logic [2:0] OFS_LIMIT    = 3'h0;
  localparam logic [2:0] OFS_ENERGY   = 3'h1;
  localparam logic [2:0] OFS_POLICY   = 3'h2;
  localparam logic [2:0] OFS_THROTTLE = 3'h3;
  localparam logic [2:0] OFS_INFO     = 3'h4;
  localparam int         DATA_W       = 64;

  // limit field group: bits 14:0 limit, 15 enable, 16 clamp, 23:17 window
  typedef struct packed {
    logic [1:0]  winFrac;
    logic [4:0]  winExp;
    logic        clamp;
    logic        enable;
    logic [14:0] limit;
  } pwl_limit_type;
  localparam int LIM_W      = 24;
  localparam int PL1_LSB    = 0;
  localparam int PL2_LSB    = 32;
  localparam int WIN_LSB    = 17;
  localparam int WIN_W      = 7;
  localparam int PKG_LOCK   = 63;
  localparam int PLANE_LOCK = 31;

  // priority field
  localparam int         PRIO_W            = 5;
  localparam logic [4:0] CORE_PRIO_RESET   = 5'h08;
  localparam logic [4:0] GFX_PRIO_RESET    = 5'h10;

  // power range info fields
  localparam int PWR_W        = 15;
  localparam int TDP_LSB      = 0;
  localparam int MINP_LSB     = 16;
  localparam int MAXP_LSB     = 32;
  localparam int MAXWIN_LSB   = 48;
  localparam int MAXWIN_W     = 6;

  // scaling unit register fields and defaults
  localparam int         PSE_LSB     = 0;
  localparam int         PSE_W       = 4;
  localparam int         ESE_LSB     = 8;
  localparam int         ESE_W       = 5;
  localparam int         TSE_LSB     = 16;
  localparam int         TSE_W       = 4;
  localparam logic [3:0] PSE_DEFAULT = 4'h3;
  localparam logic [4:0] ESE_DEFAULT = 5'h10;
  localparam logic [3:0] TSE_DEFAULT = 4'ha;

  // counters and publication period
  localparam int CNT_W            = 32;
  localparam int ENERGY_PERIOD_US = 1000;
  localparam int CLK_MHZ          = 10;
  localparam int ENERGY_TICK_CYC  = ENERGY_PERIOD_US * CLK_MHZ;
endpackage : pwl_pkg

// *** logic/pwl_regs.sv ***
`timescale 1ns/100ps
module pwl_regs #(
  parameter int                ENERGY_TICK_CYCLES = pwl_pkg::ENERGY_TICK_CYC,
  parameter int                INC_W              = 16,
  parameter bit                HARDWIRE_WIN2      = 1'b0,
  parameter logic [6:0]        WIN2_FIXED         = 7'h00,
  parameter logic [14:0]       PKG_SPEC_POWER     = 15'h0000,
  parameter logic [14:0]       PKG_MIN_POWER      = 15'h0000,
  parameter logic [14:0]       PKG_MAX_POWER      = 15'h0000,
  parameter logic [5:0]        PKG_MAX_WINDOW     = 6'h00
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // register access port
  input  wire logic                     msrRead,
  input  wire logic                     msrWrite,
  input  wire logic [pwl_pkg::DOM_W-1:0] msrDomain,
  input  wire logic [pwl_pkg::OFS_W-1:0] msrOffset,
  input  wire logic [pwl_pkg::DATA_W-1:0] msrWdata,
  output logic      [pwl_pkg::DATA_W-1:0] msrRdata,
  output logic                          msrAck,
  output logic                          msrFault,
  // measurements from the power budget controller
  input  wire logic [INC_W-1:0]         pkgEnergyInc,
  input  wire logic [INC_W-1:0]         coreEnergyInc,
  input  wire logic [INC_W-1:0]         gfxEnergyInc,
  input  wire logic                     pkgThrottleTick,
  input  wire logic                     coreThrottleTick,
  // settings to the power budget controller
  output pwl_pkg::pwl_limit_type        pkgLimit1,
  output pwl_pkg::pwl_limit_type        pkgLimit2,
  output pwl_pkg::pwl_limit_type        coreLimit,
  output pwl_pkg::pwl_limit_type        gfxLimit,
  output logic      [pwl_pkg::PRIO_W-1:0] corePrio,
  output logic      [pwl_pkg::PRIO_W-1:0] gfxPrio
);
  import pwl_pkg::*;

  localparam int TICK_W = $clog2(ENERGY_TICK_CYCLES);

  // refuse settings the logic cannot serve
  if (ENERGY_TICK_CYCLES < 2) begin : g_bad_tick
    $error("ENERGY_TICK_CYCLES must be at least 2");
  end
  if (INC_W < 1 || INC_W > CNT_W) begin : g_bad_inc
    $error("INC_W must lie between 1 and 32");
  end

  pwl_limit_type       pkgLimit1_q;
  pwl_limit_type       pkgLimit2_q;
  pwl_limit_type       coreLimit_q;
  pwl_limit_type       gfxLimit_q;
  pwl_limit_type       win2Fixed;
  logic                pkgLock_q;
  logic                coreLock_q;
  logic                gfxLock_q;
  logic [PRIO_W-1:0]   corePrio_q;
  logic [PRIO_W-1:0]   gfxPrio_q;
  logic [CNT_W-1:0]    pkgEnergyAcc_q;
  logic [CNT_W-1:0]    coreEnergyAcc_q;
  logic [CNT_W-1:0]    gfxEnergyAcc_q;
  logic [CNT_W-1:0]    pkgEnergy_q;
  logic [CNT_W-1:0]    coreEnergy_q;
  logic [CNT_W-1:0]    gfxEnergy_q;
  logic [CNT_W-1:0]    pkgThrottle_q;
  logic [CNT_W-1:0]    coreThrottle_q;
  logic [TICK_W-1:0]   tickCnt_q;
  logic                energyTick;
  logic                wrPkgLimit;
  logic                wrCoreLimit;
  logic                wrGfxLimit;
  logic                wrCorePrio;
  logic                wrGfxPrio;
  logic [DATA_W-1:0]   msrRdata_d;
  logic                msrFault_d;
  logic [DATA_W-1:0]   msrRdata_q;
  logic                msrAck_q;
  logic                msrFault_q;

  // write decode; only the limit and policy slots are writable
  assign wrPkgLimit  = msrWrite && msrDomain == DOM_PACKAGE
                       && msrOffset == OFS_LIMIT;
  assign wrCoreLimit = msrWrite && msrDomain == DOM_CORE
                       && msrOffset == OFS_LIMIT;
  assign wrGfxLimit  = msrWrite && msrDomain == DOM_GRAPHICS
                       && msrOffset == OFS_LIMIT;
  assign wrCorePrio  = msrWrite && msrDomain == DOM_CORE
                       && msrOffset == OFS_POLICY;
  assign wrGfxPrio   = msrWrite && msrDomain == DOM_GRAPHICS
                       && msrOffset == OFS_POLICY;

  // constant window two when it is wired in hardware
  always_comb begin
    win2Fixed = pwl_limit_type'(msrWdata[PL2_LSB +: LIM_W]);
    if (HARDWIRE_WIN2) begin
      {win2Fixed.winFrac, win2Fixed.winExp} = WIN2_FIXED;
    end
  end

  // package limit register; once locked it holds until reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pkgLimit1_q <= '0;
      pkgLimit2_q <= '0;
      pkgLock_q   <= 1'b0;
    end else if (wrPkgLimit && !pkgLock_q) begin
      pkgLimit1_q <= pwl_limit_type'(msrWdata[PL1_LSB +: LIM_W]);
      pkgLimit2_q <= win2Fixed;
      pkgLock_q   <= msrWdata[PKG_LOCK];
    end
  end

  // core plane limit and policy share one lock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      coreLimit_q <= '0;
      coreLock_q  <= 1'b0;
      corePrio_q  <= CORE_PRIO_RESET;
    end else if (!coreLock_q) begin
      if (wrCoreLimit) begin
        coreLimit_q <= pwl_limit_type'(msrWdata[PL1_LSB +: LIM_W]);
        coreLock_q  <= msrWdata[PLANE_LOCK];
      end
      if (wrCorePrio) begin
        corePrio_q <= msrWdata[PRIO_W-1:0];
      end
    end
  end

  // graphics plane locks on its own, independent of the core plane
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gfxLimit_q <= '0;
      gfxLock_q  <= 1'b0;
      gfxPrio_q  <= GFX_PRIO_RESET;
    end else if (!gfxLock_q) begin
      if (wrGfxLimit) begin
        gfxLimit_q <= pwl_limit_type'(msrWdata[PL1_LSB +: LIM_W]);
        gfxLock_q  <= msrWdata[PLANE_LOCK];
      end
      if (wrGfxPrio) begin
        gfxPrio_q <= msrWdata[PRIO_W-1:0];
      end
    end
  end

  // millisecond publication strobe for the energy registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tickCnt_q <= '0;
    end else if (energyTick) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + 1'b1;
    end
  end
  assign energyTick = tickCnt_q == TICK_W'(ENERGY_TICK_CYCLES - 1);

  // hidden accumulators run every cycle; software only sees the
  // snapshot, so a read never catches a half-updated sum
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pkgEnergyAcc_q  <= '0;
      coreEnergyAcc_q <= '0;
      gfxEnergyAcc_q  <= '0;
    end else begin
      pkgEnergyAcc_q  <= pkgEnergyAcc_q + CNT_W'(pkgEnergyInc);
      coreEnergyAcc_q <= coreEnergyAcc_q + CNT_W'(coreEnergyInc);
      gfxEnergyAcc_q  <= gfxEnergyAcc_q + CNT_W'(gfxEnergyInc);
    end
  end

  // visible energy counts, writes never reach them
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pkgEnergy_q  <= '0;
      coreEnergy_q <= '0;
      gfxEnergy_q  <= '0;
    end else if (energyTick) begin
      pkgEnergy_q  <= pkgEnergyAcc_q;
      coreEnergy_q <= coreEnergyAcc_q;
      gfxEnergy_q  <= gfxEnergyAcc_q;
    end
  end

  // throttled time in time units, wraps silently
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pkgThrottle_q  <= '0;
      coreThrottle_q <= '0;
    end else begin
      if (pkgThrottleTick) begin
        pkgThrottle_q <= pkgThrottle_q + 1'b1;
      end
      if (coreThrottleTick) begin
        coreThrottle_q <= coreThrottle_q + 1'b1;
      end
    end
  end

  // read data; empty slots answer zero with a fault flag
  always_comb begin
    msrRdata_d = '0;
    msrFault_d = 1'b0;
    case (msrDomain)
      DOM_PACKAGE: begin
        case (msrOffset)
          OFS_LIMIT: begin
            msrRdata_d[PL1_LSB +: LIM_W] = pkgLimit1_q;
            msrRdata_d[PL2_LSB +: LIM_W] = pkgLimit2_q;
            msrRdata_d[PKG_LOCK]         = pkgLock_q;
          end
          OFS_ENERGY:   msrRdata_d[CNT_W-1:0] = pkgEnergy_q;
          OFS_THROTTLE: msrRdata_d[CNT_W-1:0] = pkgThrottle_q;
          OFS_INFO: begin
            msrRdata_d[TDP_LSB +: PWR_W]       = PKG_SPEC_POWER;
            msrRdata_d[MINP_LSB +: PWR_W]      = PKG_MIN_POWER;
            msrRdata_d[MAXP_LSB +: PWR_W]      = PKG_MAX_POWER;
            msrRdata_d[MAXWIN_LSB +: MAXWIN_W] = PKG_MAX_WINDOW;
          end
          default: msrFault_d = 1'b1;
        endcase
      end
      DOM_CORE: begin
        case (msrOffset)
          OFS_LIMIT: begin
            msrRdata_d[PL1_LSB +: LIM_W] = coreLimit_q;
            msrRdata_d[PLANE_LOCK]       = coreLock_q;
          end
          OFS_ENERGY:   msrRdata_d[CNT_W-1:0]  = coreEnergy_q;
          OFS_POLICY:   msrRdata_d[PRIO_W-1:0] = corePrio_q;
          OFS_THROTTLE: msrRdata_d[CNT_W-1:0]  = coreThrottle_q;
          default:      msrFault_d = 1'b1;
        endcase
      end
      DOM_GRAPHICS: begin
        case (msrOffset)
          OFS_LIMIT: begin
            msrRdata_d[PL1_LSB +: LIM_W] = gfxLimit_q;
            msrRdata_d[PLANE_LOCK]       = gfxLock_q;
          end
          OFS_ENERGY: msrRdata_d[CNT_W-1:0]  = gfxEnergy_q;
          OFS_POLICY: msrRdata_d[PRIO_W-1:0] = gfxPrio_q;
          default:    msrFault_d = 1'b1;
        endcase
      end
      DOM_UNIT: begin
        if (msrOffset == OFS_LIMIT) begin
          msrRdata_d[PSE_LSB +: PSE_W] = PSE_DEFAULT;
          msrRdata_d[ESE_LSB +: ESE_W] = ESE_DEFAULT;
          msrRdata_d[TSE_LSB +: TSE_W] = TSE_DEFAULT;
        end else begin
          msrFault_d = 1'b1;
        end
      end
      default: msrFault_d = 1'b1;
    endcase
  end

  // one-cycle answer; read data holds until the next read, writes leave it alone
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      msrRdata_q <= '0;
      msrAck_q   <= 1'b0;
      msrFault_q <= 1'b0;
    end else begin
      msrAck_q   <= msrRead || msrWrite;
      msrFault_q <= (msrRead || msrWrite) && msrFault_d;
      if (msrRead) begin
        msrRdata_q <= msrRdata_d;
      end
    end
  end

  assign msrRdata  = msrRdata_q;
  assign msrAck    = msrAck_q;
  assign msrFault  = msrFault_q;
  assign pkgLimit1 = pkgLimit1_q;
  assign pkgLimit2 = pkgLimit2_q;
  assign coreLimit = coreLimit_q;
  assign gfxLimit  = gfxLimit_q;
  assign corePrio  = corePrio_q;
  assign gfxPrio   = gfxPrio_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_pkg_open_write;
    wrPkgLimit && !pkgLock_q;
  endsequence
  sequence s_pkg_locked;
    pkgLock_q ##1 wrPkgLimit;
  endsequence

  a_pkg_write_takes: assert property (
    s_pkg_open_write |=> pkgLimit1 == $past(msrWdata[LIM_W-1:0])
                         && pkgLock_q == $past(msrWdata[PKG_LOCK]))
    else $error("package limit write not stored");
  a_pkg_lock_hold: assert property (
    s_pkg_locked |=> $stable(pkgLimit1) && $stable(pkgLimit2) && pkgLock_q)
    else $error("locked package limit changed");
  a_core_lock_hold: assert property (
    coreLock_q |=> $stable(coreLimit) && $stable(corePrio) && coreLock_q)
    else $error("locked core plane changed");
  a_gfx_lock_hold: assert property (
    gfxLock_q |=> $stable(gfxLimit) && $stable(gfxPrio) && gfxLock_q)
    else $error("locked graphics plane changed");
  // the hold is checked cycle by cycle so it serves any publication period
  a_energy_publish: assert property (
    energyTick |=> pkgEnergy_q == $past(pkgEnergyAcc_q)
                   && coreEnergy_q == $past(coreEnergyAcc_q)
                   && gfxEnergy_q == $past(gfxEnergyAcc_q))
    else $error("energy snapshot wrong");
  a_energy_hold: assert property (
    !energyTick |=> $stable(pkgEnergy_q) && $stable(coreEnergy_q)
                    && $stable(gfxEnergy_q))
    else $error("energy count moved between updates");
  a_throttle_step: assert property (
    pkgThrottleTick |=> pkgThrottle_q == $past(pkgThrottle_q) + 1'b1)
    else $error("package throttle time did not advance");
  a_access_answer: assert property (
    (msrRead || msrWrite) |=> msrAck ##1 !msrAck || $past(msrRead || msrWrite))
    else $error("access not answered in one cycle");
  a_unmapped_zero: assert property (
    (msrRead && msrFault_d) |=> msrFault && msrRdata == '0)
    else $error("unmapped read not zero with fault");
  a_prio_favour: assert property (
    $rose(resetn) |-> gfxPrio_q > corePrio_q)
    else $error("reset priority does not favour graphics");
endmodule : pwl_regs

// *** sim/power_limit_domain_regs_tb.sv ***
`timescale 1ns/100ps
module power_limit_domain_regs_tb;
  import pwl_pkg::*;
  localparam int IW = 32;
  localparam logic [63:0] INFO = 64'h002a7abc04561234;
  localparam logic [63:0] UNIT = 64'h00000000000a1003;
  typedef struct packed {
    logic        wr;
    logic [1:0]  dom;
    logic [2:0]  ofs;
    logic [63:0] wd;
    logic [63:0] exp;
    logic        flt;
  } pwl_row_type;

  // bench signals
  logic                clk_sys;
  logic                resetn;
  logic                msrRead;
  logic                msrWrite;
  logic [1:0]          msrDomain;
  logic [2:0]          msrOffset;
  logic [63:0]         msrWdata;
  logic [63:0]         msrRdata;
  logic                msrAck;
  logic                msrFault;
  logic [IW-1:0]       inc [3];
  logic                pkgThrottleTick;
  logic                coreThrottleTick;
  pwl_limit_type       pkgLimit1;
  pwl_limit_type       pkgLimit2;
  pwl_limit_type       coreLimit;
  pwl_limit_type       gfxLimit;
  logic [4:0]          corePrio;
  logic [4:0]          gfxPrio;
  logic [63:0]         rd;
  logic [63:0]         v1;
  logic [63:0]         v2;
  logic                f;
  int                  failures;
  int                  cmp_count;

  // ordinary cases: reset reads, empty slots, writes with read-back
  pwl_row_type rows [16] = '{
    '{1'h0, 2'h0, 3'h0, 64'h0, 64'h0, 1'h0},
    '{1'h0, 2'h3, 3'h0, 64'h0, UNIT, 1'h0},
    '{1'h0, 2'h0, 3'h4, 64'h0, INFO, 1'h0},
    '{1'h0, 2'h1, 3'h2, 64'h0, 64'h8, 1'h0},
    '{1'h0, 2'h2, 3'h2, 64'h0, 64'h10, 1'h0},
    '{1'h0, 2'h0, 3'h2, 64'h0, 64'h0, 1'h1},
    '{1'h0, 2'h2, 3'h3, 64'h0, 64'h0, 1'h1},
    '{1'h0, 2'h0, 3'h5, 64'h0, 64'h0, 1'h1},
    // both windows Y=4 Z=1, twenty time units, inside the reported maximum
    '{1'h1, 2'h0, 3'h0, 64'h7f49ffff7f49ffff,
      64'h0049ffff0049ffff, 1'h0},
    '{1'h1, 2'h1, 3'h0, 64'hffffffff7f123456,
      64'h0000000000123456, 1'h0},
    '{1'h1, 2'h2, 3'h0, 64'h0000000000aa5555,
      64'h0000000000aa5555, 1'h0},
    '{1'h1, 2'h1, 3'h2, 64'hffffffffffffff1f, 64'h1f, 1'h0},
    '{1'h1, 2'h0, 3'h1, 64'hffffffffffffffff, 64'h0, 1'h0},
    '{1'h1, 2'h0, 3'h4, 64'hffffffffffffffff, INFO, 1'h0},
    '{1'h1, 2'h1, 3'h3, 64'hffffffffffffffff, 64'h0, 1'h0},
    '{1'h1, 2'h3, 3'h0, 64'hffffffffffffffff, UNIT, 1'h0}
  };

  // short publication period so energy steps show within a few reads
  pwl_regs #(
    .ENERGY_TICK_CYCLES (8),
    .INC_W              (IW),
    .PKG_SPEC_POWER     (15'h1234),
    .PKG_MIN_POWER      (15'h0456),
    .PKG_MAX_POWER      (15'h7abc),
    .PKG_MAX_WINDOW     (6'h2a)
  ) dut (
    .clk_sys          (clk_sys),
    .resetn           (resetn),
    .msrRead          (msrRead),
    .msrWrite         (msrWrite),
    .msrDomain        (msrDomain),
    .msrOffset        (msrOffset),
    .msrWdata         (msrWdata),
    .msrRdata         (msrRdata),
    .msrAck           (msrAck),
    .msrFault         (msrFault),
    .pkgEnergyInc     (inc[0]),
    .coreEnergyInc    (inc[1]),
    .gfxEnergyInc     (inc[2]),
    .pkgThrottleTick  (pkgThrottleTick),
    .coreThrottleTick (coreThrottleTick),
    .pkgLimit1        (pkgLimit1),
    .pkgLimit2        (pkgLimit2),
    .coreLimit        (coreLimit),
    .gfxLimit         (gfxLimit),
    .corePrio         (corePrio),
    .gfxPrio          (gfxPrio)
  );

  // clock generation
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic cmp64(input string what, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : cmp64

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // one access: request for one cycle, answer sampled one cycle later
  task automatic acc(input logic wr, input logic [1:0] dom,
                     input logic [2:0] ofs, input logic [63:0] wd);
    @(posedge clk_sys);
    msrWrite  <= wr;
    msrRead   <= ~wr;
    msrDomain <= dom;
    msrOffset <= ofs;
    msrWdata  <= wd;
    @(posedge clk_sys);
    msrWrite <= 1'b0;
    msrRead  <= 1'b0;
    #1;
    cmp64("ack", 64'h1, {63'h0, msrAck});
    rd = msrRdata;
    f  = msrFault;
  endtask : acc

  task automatic chk(input logic [1:0] dom, input logic [2:0] ofs,
                     input logic [63:0] e, input logic ef);
    acc(1'b0, dom, ofs, 64'h0);
    cmp64("read data", e, rd);
    cmp64("fault", {63'h0, ef}, {63'h0, f});
  endtask : chk

  // poll the energy count until it moves; a stuck count ends the run
  task automatic pub(input logic [1:0] dom, inout logic [63:0] v);
    int n;
    n = 0;
    rd = v;
    while (rd === v && n < 12) begin
      acc(1'b0, dom, 3'h1, 64'h0);
      n++;
    end
    if (rd === v) begin
      failures++;
      $display("MISMATCH energy update expected change seen %h", v);
      conclude();
    end else begin
      v = rd;
    end
  endtask : pub

  initial begin
    resetn = 1'b0;
    msrRead = 1'b0;
    msrWrite = 1'b0;
    msrDomain = 2'h0;
    msrOffset = 3'h0;
    msrWdata = 64'h0;
    foreach (inc[i]) inc[i] = 32'h0;
    pkgThrottleTick = 1'b0;
    coreThrottleTick = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) acc(1'b1, rows[i].dom, rows[i].ofs, rows[i].wd);
      chk(rows[i].dom, rows[i].ofs, rows[i].exp, rows[i].flt);
    end
    // limit outputs and the core priority output follow the stored fields
    cmp64("pkgLimit1", 64'h49ffff, {40'h0, pkgLimit1});
    cmp64("pkgLimit2", 64'h49ffff, {40'h0, pkgLimit2});
    cmp64("coreLimit", 64'h123456, {40'h0, coreLimit});
    cmp64("gfxLimit", 64'haa5555, {40'h0, gfxLimit});
    cmp64("corePrio", 64'h1f, {59'h0, corePrio});
    // package lock: the locking write lands, later writes do not
    acc(1'b1, 2'h0, 3'h0, 64'h8000000000012345);
    acc(1'b1, 2'h0, 3'h0, 64'h0);
    chk(2'h0, 3'h0, 64'h8000000000012345, 1'h0);
    cmp64("pkgLimit1", 64'h012345, {40'h0, pkgLimit1});
    // core plane lock also freezes its policy, graphics stays open
    acc(1'b1, 2'h1, 3'h0, 64'h80004321);
    acc(1'b1, 2'h1, 3'h0, 64'h0);
    acc(1'b1, 2'h1, 3'h2, 64'h3);
    acc(1'b1, 2'h2, 3'h2, 64'h5);
    chk(2'h1, 3'h0, 64'h80004321, 1'h0);
    chk(2'h1, 3'h2, 64'h1f, 1'h0);
    chk(2'h2, 3'h2, 64'h5, 1'h0);
    // throttle accumulators: five package ticks, three core ticks
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      pkgThrottleTick <= 1'b1;
      coreThrottleTick <= (i < 3);
    end
    @(posedge clk_sys);
    pkgThrottleTick <= 1'b0;
    coreThrottleTick <= 1'b0;
    chk(2'h0, 3'h3, 64'h5, 1'h0);
    chk(2'h1, 3'h3, 64'h3, 1'h0);
    // energy: large package step makes the count wrap within two periods
    inc[0] <= 32'h30000001;
    inc[1] <= 32'h00000100;
    inc[2] <= 32'h00000002;
    for (int d = 0; d < 3; d++) begin
      acc(1'b0, d[1:0], 3'h1, 64'h0);
      v1 = rd;
      pub(d[1:0], v1);
      v2 = v1;
      pub(d[1:0], v2);
      cmp64("energy step", {32'h0, inc[d] * 32'h8},
            {v2[63:32], v2[31:0] - v1[31:0]});
    end
    // second reset mid-run clears the lock and restores defaults
    inc[0] <= 32'h0;
    inc[1] <= 32'h0;
    inc[2] <= 32'h0;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp64("gfxPrio", 64'h10, {59'h0, gfxPrio});
    resetn <= 1'b1;
    chk(2'h0, 3'h0, 64'h0, 1'h0);
    chk(2'h1, 3'h2, 64'h8, 1'h0);
    acc(1'b1, 2'h0, 3'h0, 64'h0000800000008005);
    chk(2'h0, 3'h0, 64'h0000800000008005, 1'h0);
    conclude();
  end
endmodule : power_limit_domain_regs_tb
